// ==== rtl/irtx_pkg.sv ====
`default_nettype none
package irtx_pkg;
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int OSC_4MHZ_HZ = 4_000_000;
  localparam int OSC_PER_SYS = SYS_CLK_HZ / OSC_4MHZ_HZ;
  localparam int SUB_DIV_4MHZ = 111;
  localparam int SUB_DIV_432K = 12;
  localparam int SUBCARRIER_HZ = 36_000;
  localparam int DUTY_25_DIV = 4;
  localparam int DUTY_33_DIV = 3;
  localparam int NO_KEY_MS = 28;
  localparam int NO_KEY_TICKS = (NO_KEY_MS * SUBCARRIER_HZ + 999) / 1000;
  localparam logic [11:0] TMR_LAST = 12'hfff;
  localparam logic [11:0] TMR_RD_LO = 12'h100;
  localparam logic [11:0] TMR_RD_HI = 12'h101;
  localparam logic [11:0] TMR_LOAD = 12'h13f;
  localparam logic [2:0] GRP_IDLE = 3'h7;
  localparam logic [2:0] BANK_RESET = 3'h7;
  localparam int FRAME_W = 14;
  localparam logic [3:0] FRAME_LAST = 4'hd;
  localparam int ROM_AW = 10;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_ROM_ADDR = 12'h008;
  localparam logic [11:0] ADDR_ROM_DATA = 12'h00c;
  localparam logic CTRL_MULTI_RST = 1'b1;

  typedef enum logic [1:0] {
    ST_STOP = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

  typedef struct packed {
    logic start;
    logic field;
    logic toggle;
    logic [4:0] system;
    logic [5:0] command;
  } frame_t;

  typedef struct packed {
    logic [5:0] key;
    logic [2:0] bank;
    logic toggle;
    logic tx;
    logic running;
  } status_t;
endpackage : irtx_pkg
`default_nettype wire

// ==== rtl/irtx_core.sv ====
// Operation
// - timing generator halts when no key is active, restarts on a key press.
// - oscillator divided by 111 for 4 MHz or 12 for 432 kHz, build option.
// - divided 36 kHz clock steps the control timer; its inverse forms pulses.
// - subcarrier pulse duty factor is 25% or 33%, build option.
// - control timer spans 4096 periods; bit time 64 pulses; 64 bit times.
// - at timer end with no key for 28 ms, stop and pull drives low.
// - while stopped, a sense line going low restarts the oscillator, except sense 0 in single mode.
// - six timer bits form 64 slots; upper three drive, lower three sense.
// - each drive line low for 8 slots in turn; last 8 slots none.
// - sense low in a slot captures the 6-bit slot into key register.
// - two or more keys means no transmission and toggles next control bit.
// - single mode: sense 0 low loads bank from timer bits 5 to 7.
// - multi mode: keys change the bank; bank 7 after battery insertion.
// - bank flops load bank 7 at reset; single mode refreshes them.
// - ROM has 8 banks; bank is upper address, key register lower.
// - each command reads the ROM twice, low byte then high byte.
// - low bits 0-5 give command bits, high bits 0-4 give system bits.
// - low bit 6 is the field selector.
// - low bit 7 set inhibits transmission.
// - multi mode: high bits 5-7 choose next bank; ignored in single mode.
// - code word shifts once per bit time, biphase coded, on the subcarrier.
// - transmit output is active low.
`default_nettype none
module irtx_core #(
  parameter int OSC_DIV_SYS = irtx_pkg::OSC_PER_SYS,
  parameter bit OSC_IS_4MHZ = 1'b1,
  parameter bit DUTY_IS_33 = 1'b0
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  input wire logic [7:0] I_SENSE_LINES,
  output logic [6:0] O_DRIVE_LINES_N,
  output logic [6:0] O_DRIVE_LINES_N_OE,
  output logic O_IR_OUTPUT_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR
);
  localparam int SUB_DIV = OSC_IS_4MHZ ? irtx_pkg::SUB_DIV_4MHZ : irtx_pkg::SUB_DIV_432K;
  localparam int DUTY_DIV = DUTY_IS_33 ? irtx_pkg::DUTY_33_DIV : irtx_pkg::DUTY_25_DIV;
  localparam int PULSE_LEN = SUB_DIV / DUTY_DIV;
  localparam int SUB_SYS = SUB_DIV * OSC_DIV_SYS;
  localparam int PRE_W = $clog2(OSC_DIV_SYS + 1);
  localparam logic [PRE_W-1:0] PRE_MAX = PRE_W'(OSC_DIV_SYS - 1);
  localparam logic [6:0] DIV_MAX = 7'(SUB_DIV - 1);
  localparam logic [6:0] PULSE_END = 7'(PULSE_LEN);
  localparam logic [10:0] IDLE_MAX = 11'(irtx_pkg::NO_KEY_TICKS);

  if (OSC_DIV_SYS < 1 || SUB_SYS > 65535) begin : g_bad_div
    $error("OSC_DIV_SYS out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // sense line synchronisers
  logic [7:0] sn_meta_q;
  logic [7:0] sn_sync_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sn_meta_q <= 8'hff;
      sn_sync_q <= 8'hff;
    end else begin
      sn_meta_q <= I_SENSE_LINES;
      sn_sync_q <= sn_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and code memory
  logic multi_q, multi_d;
  logic [9:0] raddr_q, raddr_d;
  logic [31:0] prdata_q, prdata_d;
  logic slverr_q, slverr_d;
  logic [7:0] rom_mem [0:(1 << irtx_pkg::ROM_AW)-1];
  logic [7:0] rom_rd;
  logic [7:0] rom_apb;
  logic [9:0] rd_addr;
  logic setup, access, rom_we;
  irtx_pkg::status_t status;

  assign setup = I_PSEL && !I_PENABLE;
  assign access = I_PSEL && I_PENABLE;
  assign rom_we = access && I_PWRITE && (I_PADDR == irtx_pkg::ADDR_ROM_DATA);
  assign O_PREADY = access;
  assign O_PRDATA = prdata_q;
  assign O_PSLVERR = access && slverr_q;
  assign rom_apb = rom_mem[raddr_q];
  assign rom_rd = rom_mem[rd_addr];

  always_comb begin
    multi_d = multi_q;
    raddr_d = raddr_q;
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    if (setup) begin
      prdata_d = 32'h0;
      slverr_d = 1'b0;
      if (I_PADDR == irtx_pkg::ADDR_CTRL) begin
        prdata_d = {31'h0, multi_q};
      end else if (I_PADDR == irtx_pkg::ADDR_STATUS) begin
        prdata_d = 32'(status);
      end else if (I_PADDR == irtx_pkg::ADDR_ROM_ADDR) begin
        prdata_d = {22'h0, raddr_q};
      end else if (I_PADDR == irtx_pkg::ADDR_ROM_DATA) begin
        prdata_d = {24'h0, rom_apb};
      end else begin
        slverr_d = 1'b1;
      end
    end
    if (access && I_PWRITE) begin
      if (I_PADDR == irtx_pkg::ADDR_CTRL) begin
        multi_d = I_PWDATA[0];
      end else if (I_PADDR == irtx_pkg::ADDR_ROM_ADDR) begin
        raddr_d = I_PWDATA[9:0];
      end else if (I_PADDR == irtx_pkg::ADDR_ROM_DATA) begin
        raddr_d = raddr_q + 10'h001;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      multi_q <= irtx_pkg::CTRL_MULTI_RST;
      raddr_q <= 10'h000;
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else begin
      multi_q <= multi_d;
      raddr_q <= raddr_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  // mask contents are loaded by software; no reset so it maps onto plain ram
  always_ff @(posedge I_CLK_SYS) begin
    if (rom_we) begin
      rom_mem[raddr_q] <= I_PWDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator, subcarrier divider and control timer
  irtx_pkg::run_state_t state_q, state_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [6:0] div_q, div_d;
  logic [11:0] timer_q, timer_d;
  logic [10:0] idle_q, idle_d;
  logic running, osc_tick, sub_tick, wake;
  logic [7:0] wake_mask;
  logic scan_phase, sample, sense_low, key_hit, bank_hit;
  logic [2:0] grp, sns;

  assign running = (state_q == irtx_pkg::ST_RUN);
  assign osc_tick = running && (pre_q == PRE_MAX);
  assign sub_tick = osc_tick && (div_q == DIV_MAX);
  // a jumper on sense 0 would otherwise hold the part awake forever
  assign wake_mask = multi_q ? 8'hff : 8'hfe;
  assign wake = |(~sn_sync_q & wake_mask);

  assign grp = timer_q[7:5];
  assign sns = timer_q[4:2];
  assign scan_phase = (timer_q[11:8] == 4'h0);
  // sample at the slot's last period so the drive line has long settled
  assign sample = sub_tick && scan_phase && (timer_q[1:0] == 2'h3);
  assign sense_low = !sn_sync_q[sns];
  assign bank_hit = sample && !multi_q && sense_low && (sns == 3'h0);
  assign key_hit = sample && sense_low && (grp != irtx_pkg::GRP_IDLE)
                   && (multi_q || (sns != 3'h0));

  always_comb begin
    state_d = state_q;
    pre_d = pre_q;
    div_d = div_q;
    timer_d = timer_q;
    idle_d = idle_q;
    case (state_q)
      irtx_pkg::ST_STOP: begin
        pre_d = '0;
        div_d = 7'h00;
        timer_d = 12'h000;
        idle_d = 11'h000;
        if (wake) begin
          state_d = irtx_pkg::ST_RUN;
        end
      end
      irtx_pkg::ST_RUN: begin
        pre_d = osc_tick ? '0 : pre_q + 1'b1;
        if (osc_tick) begin
          div_d = sub_tick ? 7'h00 : div_q + 7'h01;
        end
        if (sub_tick) begin
          timer_d = timer_q + 12'h001;
          if (key_hit) begin
            idle_d = 11'h000;
          end else if (idle_q != IDLE_MAX) begin
            idle_d = idle_q + 11'h001;
          end
          if (timer_q == irtx_pkg::TMR_LAST && idle_q == IDLE_MAX) begin
            state_d = irtx_pkg::ST_STOP;
          end
        end
      end
      default: begin
        state_d = irtx_pkg::ST_STOP;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q <= irtx_pkg::ST_STOP;
      pre_q <= '0;
      div_q <= 7'h00;
      timer_q <= 12'h000;
      idle_q <= 11'h000;
    end else begin
      state_q <= state_d;
      pre_q <= pre_d;
      div_q <= div_d;
      timer_q <= timer_d;
      idle_q <= idle_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key capture, code fetch and biphase transmitter
  logic [5:0] key_q, key_d;
  logic [1:0] hits_q, hits_d;
  logic [2:0] bank_q, bank_d;
  logic toggle_q, toggle_d;
  logic [7:0] lo_q, lo_d;
  logic [7:0] hi_q, hi_d;
  irtx_pkg::frame_t shift_q, shift_d;
  logic [3:0] bits_q, bits_d;
  logic tx_q, tx_d;
  logic ir_n_q, ir_n_d;
  logic [6:0] drive_oe_q, drive_oe_d;
  logic carrier;

  assign rd_addr = {bank_q, key_q, timer_q == irtx_pkg::TMR_RD_HI};
  assign status = '{key: key_q, bank: bank_q, toggle: toggle_q, tx: tx_q, running: running};
  assign O_DRIVE_LINES_N = 7'h00;
  assign O_DRIVE_LINES_N_OE = drive_oe_q;
  assign O_IR_OUTPUT_N = ir_n_q;

  always_comb begin
    key_d = key_q;
    hits_d = hits_q;
    bank_d = bank_q;
    toggle_d = toggle_q;
    lo_d = lo_q;
    hi_d = hi_q;
    shift_d = shift_q;
    bits_d = bits_q;
    tx_d = tx_q;
    if (sub_tick && timer_q == irtx_pkg::TMR_LAST) begin
      hits_d = 2'h0;
    end
    if (key_hit) begin
      if (hits_q == 2'h0) begin
        key_d = timer_q[7:2];
      end
      if (hits_q != 2'h2) begin
        hits_d = hits_q + 2'h1;
      end
    end
    if (bank_hit) begin
      bank_d = grp;
    end
    if (sub_tick && timer_q == irtx_pkg::TMR_RD_LO) begin
      lo_d = rom_rd;
    end
    if (sub_tick && timer_q == irtx_pkg::TMR_RD_HI) begin
      hi_d = rom_rd;
    end
    if (sub_tick && tx_q && timer_q[5:0] == 6'h3f) begin
      shift_d = irtx_pkg::frame_t'({shift_q[irtx_pkg::FRAME_W-2:0], 1'b0});
      bits_d = bits_q + 4'h1;
      if (bits_q == irtx_pkg::FRAME_LAST) begin
        tx_d = 1'b0;
      end
    end
    if (sub_tick && timer_q == irtx_pkg::TMR_LOAD) begin
      if (hits_q == 2'h1) begin
        if (multi_q) begin
          bank_d = hi_q[7:5];
        end
        if (!lo_q[7]) begin
          tx_d = 1'b1;
          bits_d = 4'h0;
          shift_d = '{start: 1'b1, field: lo_q[6], toggle: toggle_q,
                      system: hi_q[4:0], command: lo_q[5:0]};
        end
      end else if (hits_q == 2'h2) begin
        toggle_d = !toggle_q;
      end
    end
    // a one is sent as silence then burst, a zero as burst then silence
    carrier = tx_q && (shift_q.start ? timer_q[5] : !timer_q[5])
              && running && (div_q < PULSE_END);
    ir_n_d = !carrier;
    if (!running) begin
      drive_oe_d = 7'h7f;
    end else if (scan_phase && grp != irtx_pkg::GRP_IDLE) begin
      drive_oe_d = 7'h01 << grp;
    end else begin
      drive_oe_d = 7'h00;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      key_q <= 6'h00;
      hits_q <= 2'h0;
      bank_q <= irtx_pkg::BANK_RESET;
      toggle_q <= 1'b0;
      lo_q <= 8'h00;
      hi_q <= 8'h00;
      shift_q <= '0;
      bits_q <= 4'h0;
      tx_q <= 1'b0;
      ir_n_q <= 1'b1;
      drive_oe_q <= 7'h7f;
    end else begin
      key_q <= key_d;
      hits_q <= hits_d;
      bank_q <= bank_d;
      toggle_q <= toggle_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      shift_q <= shift_d;
      bits_q <= bits_d;
      tx_q <= tx_d;
      ir_n_q <= ir_n_d;
      drive_oe_q <= drive_oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] gap_q;
  logic gap_ok_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      gap_q <= 16'h0000;
      gap_ok_q <= 1'b0;
    end else if (!running) begin
      gap_q <= 16'h0000;
      gap_ok_q <= 1'b0;
    end else if (sub_tick) begin
      gap_q <= 16'h0000;
      gap_ok_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESET_N);

  sequence s_multi_eval;
    sub_tick && timer_q == irtx_pkg::TMR_LOAD && hits_q == 2'h2;
  endsequence

  sequence s_toggled_quiet;
    ##1 (toggle_q != $past(toggle_q)) && !tx_q;
  endsequence

  sequence s_one_first_half;
    tx_q && shift_q.start && !timer_q[5];
  endsequence

  a_sub_period: assert property (sub_tick && gap_ok_q |-> gap_q == 16'(SUB_SYS - 1))
    else $error("subcarrier period wrong");
  a_timer_wrap: assert property (sub_tick && timer_q == irtx_pkg::TMR_LAST
    && idle_q != IDLE_MAX |=> running && timer_q == 12'h000)
    else $error("control timer did not wrap");
  a_stop_drive: assert property (!running |=> O_DRIVE_LINES_N_OE == 7'h7f)
    else $error("drive lines not low while stopped");
  a_wake_start: assert property (!running && wake |=> running)
    else $error("sense low did not restart");
  a_scan_drive: assert property (running && scan_phase && grp != irtx_pkg::GRP_IDLE
    |=> O_DRIVE_LINES_N_OE == (7'h01 << $past(grp)))
    else $error("wrong drive line in scan slot");
  a_key_capture: assert property (key_hit && hits_q == 2'h0
    |=> key_q == $past(timer_q[7:2]))
    else $error("key slot not captured");
  a_multi_key: assert property (s_multi_eval |-> s_toggled_quiet)
    else $error("multiple keys not suppressed");
  a_bank_single: assert property (bank_hit |=> bank_q == $past(grp))
    else $error("bank not loaded from jumper");
  a_inhibit_quiet: assert property (sub_tick && timer_q == irtx_pkg::TMR_LOAD
    && lo_q[7] && !tx_q |=> !tx_q)
    else $error("inhibited code transmitted");
  a_biphase_one: assert property (s_one_first_half |=> O_IR_OUTPUT_N)
    else $error("burst in first half of a one");
  a_out_idle: assert property (!tx_q |=> O_IR_OUTPUT_N)
    else $error("output active while idle");
endmodule : irtx_core
`default_nettype wire

// ==== test/key_matrix_model.sv ====
`default_nettype none
module key_matrix_model (
  input wire logic [6:0] i_drive_oe,
  input wire logic [55:0] i_keys,
  input wire logic i_jumper_en,
  input wire logic [2:0] i_jumper_line,
  output logic [7:0] o_sense
);
  timeunit 1ns;
  timeprecision 1ns;

  // weak pull-ups: a sense line reads low only through a closed key on a pulled drive line or through the jumper
  always_comb begin
    o_sense = 8'hff;
    for (int d = 0; d < 7; d++) begin
      for (int s = 0; s < 8; s++) begin
        if (i_keys[d * 8 + s] && i_drive_oe[d]) begin
          o_sense[s] = 1'b0;
        end
      end
    end
    // line 7 stands for a jumper to ground
    if (i_jumper_en && (i_jumper_line == 3'h7 || i_drive_oe[i_jumper_line])) begin
      o_sense[0] = 1'b0;
    end
  end
endmodule : key_matrix_model
`default_nettype wire

// ==== test/ir_keypad_biphase_transmitter_tb.sv ====
`default_nettype none
module ir_keypad_biphase_transmitter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER = irtx_pkg::SUB_DIV_432K;
  localparam int HALF = 32 * PER;
  localparam logic [11:0] A_ST = irtx_pkg::ADDR_STATUS;
  localparam logic [11:0] A_RA = irtx_pkg::ADDR_ROM_ADDR;
  localparam logic [11:0] A_RD = irtx_pkg::ADDR_ROM_DATA;
  localparam logic [11:0] A_CT = irtx_pkg::ADDR_CTRL;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sense;
  logic [6:0] oe;
  logic ir;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [55:0] keys = 56'h0;
  logic [6:0] drv;
  logic jmp_en = 1'b0;
  int fail_count = 0;
  int check_count = 0;

  always #25 clk = ~clk;

  key_matrix_model u_key_matrix_model (
    .i_drive_oe(oe),
    .i_keys(keys),
    .i_jumper_en(jmp_en),
    .i_jumper_line(3'h2),
    .o_sense(sense)
  );

  // smallest divider keeps a full repetition short enough to simulate
  irtx_core #(.OSC_DIV_SYS(1), .OSC_IS_4MHZ(1'b0), .DUTY_IS_33(1'b0)) u_irtx_core (
    .I_CLK_SYS(clk),
    .I_RESET_N(rst_n),
    .I_SENSE_LINES(sense),
    .O_DRIVE_LINES_N(drv),
    .O_DRIVE_LINES_N_OE(oe),
    .O_IR_OUTPUT_N(ir),
    .I_PSEL(psel),
    .I_PENABLE(penable),
    .I_PWRITE(pwrite),
    .I_PADDR(paddr),
    .I_PWDATA(pwdata),
    .O_PRDATA(prdata),
    .O_PREADY(pready),
    .O_PSLVERR(pslverr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic err;
    apb(1'b1, a, d, q, err);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic err;
    apb(1'b0, a, 32'h0, q, err);
  endtask : rd

  task automatic count_low(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      if (ir === 1'b0) begin
        c++;
      end
    end
  endtask : count_low

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    logic [31:0] q;
    logic err;
    logic [13:0] frame;
    int lo_a;
    int lo_b;
    int n;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    check("oe at reset", 32'h7f, 32'(oe));
    check("drive value", 32'h0, 32'(drv));
    check("ir idle", 32'h1, 32'(ir));
    rd(A_ST, q);
    check("bank at reset", 32'h7, (q >> 3) & 32'h7);
    check("stopped", 32'h0, q & 32'h1);
    apb(1'b0, 12'h010, 32'h0, q, err);
    check("unmapped err", 32'h1, 32'(err));
    // bank 7 key 10: command 25, field 1, system 0b, next bank 2
    wr(A_RA, 32'h394);
    wr(A_RD, 32'h65);
    wr(A_RD, 32'h4b);
    wr(A_RA, 32'h114);
    repeat (4) wr(A_RD, 32'h80);
    wr(A_RA, 32'h394);
    rd(A_RD, q);
    check("rom readback", 32'h65, q);
    keys[10] <= 1'b1;
    repeat (6) @(posedge clk);
    rd(A_ST, q);
    check("wake", 32'h1, q & 32'h1);
    for (int j = 1; j < 7; j++) begin
      while (oe !== 7'(1 << j)) @(posedge clk);
      n = 0;
      while (oe === 7'(1 << j)) begin
        @(posedge clk);
        n++;
      end
      check("drive slot length", 32 * PER, n);
    end
    check("last group idle", 32'h0, 32'(oe));
    // the start bit's first half is silent, so the first low opens its second half
    while (ir !== 1'b0) @(posedge clk);
    count_low(HALF - 1, lo_a);
    check("burst low time", 32 * (PER / irtx_pkg::DUTY_25_DIV), lo_a + 1);
    frame[13] = 1'b1;
    for (int k = 12; k >= 0; k--) begin
      count_low(HALF, lo_a);
      count_low(HALF, lo_b);
      frame[k] = (lo_a == 0) && (lo_b > 0);
      check("one burst per bit", 32'h1, 32'((lo_a == 0) != (lo_b == 0)));
    end
    check("frame", {1'b1, 1'b1, 1'b0, 5'h0b, 6'h25}, frame);
    keys[10] <= 1'b0;
    rd(A_ST, q);
    check("key register", 32'd10, (q >> 6) & 32'h3f);
    check("next bank", 32'h2, (q >> 3) & 32'h7);
    n = 0;
    while (oe !== 7'h7f) begin
      @(posedge clk);
      n++;
    end
    check("idle before stop", 32'h1, 32'(n > 1008 * PER));
    rd(A_ST, q);
    check("stopped again", 32'h0, q & 32'h1);
    keys[10] <= 1'b1;
    keys[11] <= 1'b1;
    count_low(1300 * PER, lo_a);
    check("no tx two keys", 32'h0, lo_a);
    rd(A_ST, q);
    check("toggle flipped", 32'h1, (q >> 2) & 32'h1);
    check("bank kept", 32'h2, (q >> 3) & 32'h7);
    keys <= 56'h0;
    // reset again in mid-run, then single-system mode with a jumper to drive line 2
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    check("oe after reset", 32'h7f, 32'(oe));
    check("ir after reset", 32'h1, 32'(ir));
    rd(A_ST, q);
    check("bank after reset", 32'h7, (q >> 3) & 32'h7);
    check("stopped after reset", 32'h0, q & 32'h1);
    wr(A_CT, 32'h0);
    rd(A_CT, q);
    check("single mode set", 32'h0, q);
    jmp_en <= 1'b1;
    repeat (6) @(posedge clk);
    rd(A_ST, q);
    check("jumper no wake", 32'h0, q & 32'h1);
    // bank 2 key 10 holds an inhibited code, so the scan must stay silent
    keys[10] <= 1'b1;
    count_low(400 * PER, lo_a);
    check("inhibited no tx", 32'h0, lo_a);
    rd(A_ST, q);
    check("jumper bank", 32'h2, (q >> 3) & 32'h7);
    check("single key", 32'd10, (q >> 6) & 32'h3f);
    keys <= 56'h0;
    print_verdict();
  end
endmodule : ir_keypad_biphase_transmitter_tb
`default_nettype wire
